//--- inc/reset_remap_map.vh
// register map, field positions, reset values and timing counts of the
// reset cause and remap controller.
// assumes a 32-bit byte address bus with 8-bit registers in the low lanes.
`ifndef RESET_REMAP_MAP_VH
`define RESET_REMAP_MAP_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define OFS_MEMORY_SWAP_CONTROL   32'hFFFF0220
`define OFS_RESET_CAUSE_FLAGS    32'hFFFF0230
`define OFS_RESET_CAUSE_CLEAR    32'hFFFF0234
`define OFS_RETAIN_UNLOCK_KEY    32'h0FFF0248
`define OFS_RESET_RETENTION_CFG  32'hFFFF024C
`define OFS_RETAIN_COMMIT_KEY    32'h0FFF0250
`define OFS_IRQ_STATUS           32'hFFFF0260
`define OFS_IRQ_MASK             32'hFFFF0264

// ****************************************************************
// field positions
// ****************************************************************
`define SWAP_SRAM_BIT            0
`define CAUSE_POWER_ON_BIT       0
`define CAUSE_WATCHDOG_BIT       1
`define CAUSE_SOFTWARE_BIT       2
`define CAUSE_USED_MASK          8'h07
`define RETAIN_GPIO_BIT          0
`define RETAIN_VDAC_BIT          2
`define RETAIN_CURRENT_OUTPUT_CONVERTER_BIT          3
`define RETAIN_WRITABLE_MASK     8'h0D
`define IRQ_WARM_RESET_BIT       0
`define IRQ_KEY_ERROR_BIT        1
`define IRQ_COMMIT_BIT           2
`define IRQ_USED_MASK            8'h07

// ****************************************************************
// reset values and key codes
// ****************************************************************
`define MEMORY_SWAP_RESET        8'h00
`define RESET_CAUSE_POR_VALUE    8'h01
`define RETENTION_RESET          8'h00
`define IRQ_RESET                8'h00
`define UNLOCK_KEY_CODE          8'h76
`define COMMIT_KEY_CODE          8'hB1

// ****************************************************************
// timing
// ****************************************************************
`define RESET_PULSE_CYCLES       4

`endif

//--- rtl/reset_cause_remap_control.v
// reset cause flags, memory swap control and key protected retention
// configuration, with one level interrupt output.
// assumes a single 100 MHz clock, a plain one-cycle strobe register port,
// and a watchdog that pulses for one cycle on the same clock.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "reset_remap_map.vh"

module reset_cause_remap_control #(
	parameter PULSE_CYCLES = `RESET_PULSE_CYCLES
) (
	// clock and power-on reset
	input  wire        clk,
	input  wire        rst_n,
	// register port
	input  wire [31:0] addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	// reset sources
	input  wire        ext_reset_n,
	input  wire        watchdog_timeout,
	// memory map and reset outputs
	output wire        sram_at_zero,
	output wire        sys_reset,
	output wire        current_output_converter_reset,
	output wire        voltage_dac_reset,
	output wire        gpio_reset,
	// interrupt
	output wire        irq
);

	// ****************************************************************
	// local constants
	// ****************************************************************
	localparam [2:0] KEY_IDLE     = 3'b001;
	localparam [2:0] KEY_UNLOCKED = 3'b010;
	localparam [2:0] KEY_STAGED   = 3'b100;
	localparam [7:0] SWAP_RESET   = `MEMORY_SWAP_RESET;
	localparam       CW           = 8;

	function hit;
		input [31:0] a;
		input [31:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	// ****************************************************************
	// reset release and pin synchroniser
	// ****************************************************************
	reg        rst_meta_reg;
	reg        rst_sync_reg;
	wire       rst_i_n = rst_sync_reg;
	reg  [2:0] ext_sync_reg;
	reg        ext_level_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// only stage two and three are compared; stage one feeds stage two only
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			ext_sync_reg  <= 3'b111;
			ext_level_reg <= 1'b1;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], ext_reset_n};
			if (ext_sync_reg[1] == ext_sync_reg[2])
				ext_level_reg <= ext_sync_reg[2];
		end
	end

	wire ext_fall = ext_level_reg && (ext_sync_reg[1] == ext_sync_reg[2])
		&& !ext_sync_reg[2];

	// ****************************************************************
	// register decode
	// ****************************************************************
	wire wr_swap   = wr && hit(addr, `OFS_MEMORY_SWAP_CONTROL);
	wire wr_flags  = wr && hit(addr, `OFS_RESET_CAUSE_FLAGS);
	wire wr_clear  = wr && hit(addr, `OFS_RESET_CAUSE_CLEAR);
	wire wr_key0   = wr && hit(addr, `OFS_RETAIN_UNLOCK_KEY);
	wire wr_cfg    = wr && hit(addr, `OFS_RESET_RETENTION_CFG);
	wire wr_key1   = wr && hit(addr, `OFS_RETAIN_COMMIT_KEY);
	wire wr_istat  = wr && hit(addr, `OFS_IRQ_STATUS);
	wire wr_imask  = wr && hit(addr, `OFS_IRQ_MASK);

	// ****************************************************************
	// reset cause flags and warm reset triggers
	// ****************************************************************
	reg  [CW-1:0] cause_reg;
	reg  [CW-1:0] cause_next;
	wire          sw_force = wr_flags && wdata[`CAUSE_SOFTWARE_BIT];
	// a clear that leaves some set flag standing is punished with a reset
	wire          bad_clear = wr_clear &&
		((cause_reg & ~wdata[CW-1:0] & `CAUSE_USED_MASK) != 8'h00);
	wire          warm_req = watchdog_timeout || sw_force || bad_clear;

	always @* begin
		cause_next = cause_reg;
		// a pin reset wipes the causes, so an all-zero read names the pin
		if (ext_fall)
			cause_next = 8'h00;
		if (wr_clear)
			cause_next = cause_next & ~wdata[CW-1:0];
		// setting wins over a clear in the same cycle
		if (sw_force)
			cause_next[`CAUSE_SOFTWARE_BIT] = 1'b1;
		if (watchdog_timeout)
			cause_next[`CAUSE_WATCHDOG_BIT] = 1'b1;
		cause_next = cause_next & `CAUSE_USED_MASK;
	end

	// only power-on loads a cause of its own; flags survive warm resets
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n)
			cause_reg <= `RESET_CAUSE_POR_VALUE;
		else
			cause_reg <= cause_next;
	end

	// ****************************************************************
	// reset pulse generator
	// ****************************************************************
	reg  [7:0] pulse_cnt_reg;
	reg  [7:0] pulse_cnt_next;
	reg        warm_kind_reg;
	reg        warm_kind_next;
	reg  [2:0] keep_reg;
	reg  [2:0] keep_next;
	reg  [7:0] retain_reg;
	reg        sys_reset_reg;
	reg  [2:0] periph_reset_reg;
	wire [2:0] periph_reset_next;
	wire       any_reset     = warm_req || ext_fall;
	wire       pulse_on      = (pulse_cnt_reg != 8'h00);
	wire       pulse_on_next = (pulse_cnt_next != 8'h00);

	always @* begin
		pulse_cnt_next = pulse_cnt_reg;
		warm_kind_next = warm_kind_reg;
		keep_next      = keep_reg;
		if (any_reset && !pulse_on) begin
			pulse_cnt_next = PULSE_CYCLES[7:0];
			// external pin reset never keeps anything
			warm_kind_next = !ext_fall;
			keep_next      = ext_fall ? 3'b000 :
				{retain_reg[`RETAIN_CURRENT_OUTPUT_CONVERTER_BIT], retain_reg[`RETAIN_VDAC_BIT],
				 retain_reg[`RETAIN_GPIO_BIT]};
		end else if (pulse_on) begin
			pulse_cnt_next = pulse_cnt_reg - 8'h01;
		end
	end

	// keep bit order is current converters, voltage converters, gpio
	genvar p;
	generate
		for (p = 0; p < 3; p = p + 1) begin : g_keep
			assign periph_reset_next[p] = pulse_on_next &&
				!(warm_kind_next && keep_next[p]);
		end
	endgenerate

	// reset outputs come straight from flops so they cannot glitch;
	// a zero pulse length is not supported, power-on always pulses
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			pulse_cnt_reg    <= PULSE_CYCLES[7:0];
			warm_kind_reg    <= 1'b0;
			keep_reg         <= 3'b000;
			sys_reset_reg    <= 1'b1;
			periph_reset_reg <= 3'b111;
		end else begin
			pulse_cnt_reg    <= pulse_cnt_next;
			warm_kind_reg    <= warm_kind_next;
			keep_reg         <= keep_next;
			sys_reset_reg    <= pulse_on_next;
			periph_reset_reg <= periph_reset_next;
		end
	end

	assign sys_reset = sys_reset_reg;
	assign current_output_converter_reset = periph_reset_reg[2];
	assign voltage_dac_reset = periph_reset_reg[1];
	assign gpio_reset = periph_reset_reg[0];

	// ****************************************************************
	// memory swap control
	// ****************************************************************
	reg swap_reg;

	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n)
			swap_reg <= SWAP_RESET[`SWAP_SRAM_BIT];
		else if (any_reset || pulse_on)
			swap_reg <= 1'b0;
		else if (wr_swap)
			swap_reg <= wdata[`SWAP_SRAM_BIT];
	end

	assign sram_at_zero = swap_reg;

	// ****************************************************************
	// key protected retention configuration
	// ****************************************************************
	reg [2:0] key_state_reg;
	reg [7:0] staged_reg;
	reg       key_err;
	reg       commit;

	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			key_state_reg <= KEY_IDLE;
			staged_reg    <= `RETENTION_RESET;
			retain_reg    <= `RETENTION_RESET;
		end else if (any_reset || pulse_on) begin
			key_state_reg <= KEY_IDLE;
			retain_reg    <= `RETENTION_RESET;
		end else begin
			if (commit)
				retain_reg <= staged_reg & `RETAIN_WRITABLE_MASK;
			if (wr) begin
				case (key_state_reg)
				KEY_IDLE: begin
					if (wr_key0 && wdata[7:0] == `UNLOCK_KEY_CODE)
						key_state_reg <= KEY_UNLOCKED;
				end
				KEY_UNLOCKED: begin
					if (wr_cfg) begin
						staged_reg    <= wdata[7:0];
						key_state_reg <= KEY_STAGED;
					end else begin
						key_state_reg <= KEY_IDLE;
					end
				end
				KEY_STAGED: begin
					key_state_reg <= KEY_IDLE;
				end
				default: begin
					key_state_reg <= KEY_IDLE;
				end
				endcase
			end
		end
	end

	// any write that breaks the sequence drops it and is flagged
	always @* begin
		key_err = 1'b0;
		commit  = 1'b0;
		if (wr) begin
			case (key_state_reg)
			KEY_IDLE: begin
				key_err = wr_cfg || wr_key1 ||
					(wr_key0 && wdata[7:0] != `UNLOCK_KEY_CODE);
			end
			KEY_UNLOCKED: begin
				key_err = !wr_cfg;
			end
			KEY_STAGED: begin
				commit  = wr_key1 && wdata[7:0] == `COMMIT_KEY_CODE;
				key_err = !commit;
			end
			default: begin
				key_err = 1'b1;
			end
			endcase
		end
	end

	// ****************************************************************
	// interrupt status and mask
	// ****************************************************************
	reg  [CW-1:0] istat_reg;
	reg  [CW-1:0] imask_reg;
	wire [CW-1:0] ievent = {5'h00, commit, key_err, any_reset && !pulse_on};

	// status and mask survive warm resets so the cause can be serviced
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			istat_reg <= `IRQ_RESET;
			imask_reg <= `IRQ_RESET;
		end else begin
			istat_reg <= ((wr_istat ? istat_reg & ~wdata[CW-1:0] : istat_reg)
				| ievent) & `IRQ_USED_MASK;
			if (wr_imask)
				imask_reg <= wdata[CW-1:0] & `IRQ_USED_MASK;
		end
	end

	assign irq = |(istat_reg & imask_reg);

	// ****************************************************************
	// read port, data one cycle after the strobe
	// ****************************************************************
	reg [7:0] rsel;

	always @* begin
		rsel = 8'h00;
		if (hit(addr, `OFS_MEMORY_SWAP_CONTROL))
			rsel = {7'h00, swap_reg};
		else if (hit(addr, `OFS_RESET_CAUSE_FLAGS))
			rsel = cause_reg;
		else if (hit(addr, `OFS_RESET_RETENTION_CFG))
			rsel = retain_reg;
		else if (hit(addr, `OFS_IRQ_STATUS))
			rsel = istat_reg;
		else if (hit(addr, `OFS_IRQ_MASK))
			rsel = imask_reg;
		// keys, the clear register and unmapped addresses read zero
		else
			rsel = 8'h00;
	end

	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n)
			rdata <= 32'h00000000;
		else if (rd)
			rdata <= {24'h000000, rsel};
		else
			rdata <= 32'h00000000;
	end

endmodule

//--- verif/reset_cause_remap_control_checker.sv
// concurrent checks on the ports of the reset cause and remap controller.
// assumes it is bound to the design top, sharing its clock and reset.
`timescale 1ns/1ps
`include "reset_remap_map.vh"

module reset_cause_remap_control_checker #(
	parameter PULSE_CYCLES = 4
) (
	// clock and reset
	input logic        clk,
	input logic        rst_n,
	// register port
	input logic [31:0] addr,
	input logic [31:0] wdata,
	input logic        wr,
	input logic        rd,
	input logic [31:0] rdata,
	// reset path
	input logic        watchdog_timeout,
	input logic        sram_at_zero,
	input logic        sys_reset,
	input logic        current_output_converter_reset,
	input logic        voltage_dac_reset,
	input logic        gpio_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ****************************************************************
	// pulse length counter
	// ****************************************************************
	// the first pulse after power-on also spans the reset synchroniser,
	// so only pulses after a low phase are measured
	logic [7:0] run_reg;
	logic       armed_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_reg <= 8'h00;
			armed_reg <= 1'b0;
		end else begin
			run_reg <= sys_reset ? run_reg + 8'h01 : 8'h00;
			armed_reg <= armed_reg | !sys_reset;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	a_idle_read_zero: assert property (!rd |=> rdata == 32'h0)
		else $error("read data not zero outside read answer");
	a_key_reads_zero: assert property (rd && (addr == `OFS_RETAIN_UNLOCK_KEY ||
		addr == `OFS_RETAIN_COMMIT_KEY) |=> rdata == 32'h0)
		else $error("key register read not zero");
	a_flags_reserved: assert property (rd && addr == `OFS_RESET_CAUSE_FLAGS
		|=> rdata[31:3] == 29'h0)
		else $error("reserved cause bits set");
	a_cfg_reserved: assert property (rd && addr == `OFS_RESET_RETENTION_CFG
		|=> (rdata & ~32'h0D) == 32'h0)
		else $error("reserved retention bits set");
	a_swap_write: assert property (wr && addr == `OFS_MEMORY_SWAP_CONTROL &&
		!sys_reset && !watchdog_timeout |=> sram_at_zero == $past(wdata[0]))
		else $error("swap bit not taken from write");
	a_wd_trigger: assert property (watchdog_timeout && !sys_reset |=> sys_reset)
		else $error("watchdog did not start reset");
	a_soft_trigger: assert property (wr && addr == `OFS_RESET_CAUSE_FLAGS &&
		wdata[2] && !sys_reset |=> sys_reset)
		else $error("software reset not started");
	a_swap_cleared: assert property ($rose(sys_reset) |-> !sram_at_zero)
		else $error("swap bit survived reset");
	a_pulse_length: assert property ($fell(sys_reset) && armed_reg |->
		run_reg == PULSE_CYCLES)
		else $error("reset pulse length wrong");
	a_periph_quiet: assert property (!sys_reset |-> !gpio_reset &&
		!voltage_dac_reset && !current_output_converter_reset)
		else $error("peripheral reset outside system reset");

	c_watchdog: cover property (watchdog_timeout && !sys_reset);
	c_retained: cover property (sys_reset && !gpio_reset);
	c_swap: cover property ($rose(sram_at_zero));
endmodule

//--- verif/reset_cause_remap_control_test.sv
// self-checking bench for the reset cause and remap controller.
// assumes the register map header and a short reset pulse parameter.
`timescale 1ns/1ps
`include "reset_remap_map.vh"

module reset_cause_remap_control_test;
	localparam PULSE = 2;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ext_reset_n = 1'b1;
	logic        watchdog_timeout = 1'b0;
	logic [31:0] rdata;
	logic        sram_at_zero, sys_reset, irq;
	logic        cur_rst, volt_rst, gpio_rst;
	int          num_errors = 0;
	int          compares = 0;
	int          cycles = 0;

	reset_cause_remap_control #(.PULSE_CYCLES(PULSE)) DUT (
		.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .ext_reset_n(ext_reset_n),
		.watchdog_timeout(watchdog_timeout), .sram_at_zero(sram_at_zero),
		.sys_reset(sys_reset), .current_output_converter_reset(cur_rst),
		.voltage_dac_reset(volt_rst), .gpio_reset(gpio_rst), .irq(irq)
	);

	initial begin
		forever #5 clk = ~clk;
	end

	// ****************************************************************
	// access tasks
	// ****************************************************************
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string n, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input string n, input logic [31:0] a,
		input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(n, e, rdata);
	endtask

	// called just after the edge that takes a trigger; e is cur,volt,gpio
	task automatic pulse_chk(input logic [2:0] e);
		#1;
		check("reset outputs", {28'h0, 1'b1, e},
			{28'h0, sys_reset, cur_rst, volt_rst, gpio_rst});
		repeat (PULSE + 6) @(posedge clk);
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			num_errors++;
			print_verdict();
		end
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (PULSE + 8) @(posedge clk);
		rd_chk("flags", `OFS_RESET_CAUSE_FLAGS, 32'h01);
		rd_chk("swap", `OFS_MEMORY_SWAP_CONTROL, 32'h00);
		rd_chk("cfg", `OFS_RESET_RETENTION_CFG, 32'h00);
		rd_chk("key0", `OFS_RETAIN_UNLOCK_KEY, 32'h00);
		rd_chk("key1", `OFS_RETAIN_COMMIT_KEY, 32'h00);
		rd_chk("unmapped", 32'hFFFF0240, 32'h00);
		$display("test defaults done");
		wr_reg(`OFS_MEMORY_SWAP_CONTROL, 32'h01);
		#1 check("sram_at_zero", 32'h1, {31'h0, sram_at_zero});
		rd_chk("swap", `OFS_MEMORY_SWAP_CONTROL, 32'h01);
		wr_reg(`OFS_RESET_CAUSE_FLAGS, 32'h03);
		rd_chk("flags", `OFS_RESET_CAUSE_FLAGS, 32'h01);
		wr_reg(`OFS_RESET_CAUSE_CLEAR, 32'h01);
		rd_chk("flags", `OFS_RESET_CAUSE_FLAGS, 32'h00);
		$display("test swap and flags done");
		wr_reg(`OFS_RETAIN_UNLOCK_KEY, 32'h76);
		wr_reg(`OFS_RESET_RETENTION_CFG, 32'h0D);
		wr_reg(`OFS_RETAIN_COMMIT_KEY, 32'hB1);
		rd_chk("cfg", `OFS_RESET_RETENTION_CFG, 32'h0D);
		wr_reg(`OFS_RESET_RETENTION_CFG, 32'h00);
		wr_reg(`OFS_RETAIN_UNLOCK_KEY, 32'h76);
		wr_reg(`OFS_RESET_RETENTION_CFG, 32'h00);
		wr_reg(`OFS_MEMORY_SWAP_CONTROL, 32'h01);
		wr_reg(`OFS_RETAIN_COMMIT_KEY, 32'hB1);
		rd_chk("cfg", `OFS_RESET_RETENTION_CFG, 32'h0D);
		$display("test key sequence done");
		rd_chk("irq mask", `OFS_IRQ_MASK, 32'h00);
		check("irq masked", 32'h0, {31'h0, irq});
		rd_chk("irq status", `OFS_IRQ_STATUS, 32'h06);
		wr_reg(`OFS_IRQ_MASK, 32'h07);
		#1 check("irq raised", 32'h1, {31'h0, irq});
		wr_reg(`OFS_IRQ_STATUS, 32'h07);
		#1 check("irq cleared", 32'h0, {31'h0, irq});
		$display("test interrupt done");
		@(posedge clk);
		watchdog_timeout <= 1'b1;
		@(posedge clk);
		watchdog_timeout <= 1'b0;
		pulse_chk(3'b000);
		rd_chk("flags", `OFS_RESET_CAUSE_FLAGS, 32'h02);
		rd_chk("swap", `OFS_MEMORY_SWAP_CONTROL, 32'h00);
		rd_chk("cfg", `OFS_RESET_RETENTION_CFG, 32'h00);
		wr_reg(`OFS_RESET_CAUSE_FLAGS, 32'h04);
		pulse_chk(3'b111);
		rd_chk("flags", `OFS_RESET_CAUSE_FLAGS, 32'h06);
		wr_reg(`OFS_RESET_CAUSE_CLEAR, 32'h02);
		pulse_chk(3'b111);
		rd_chk("flags", `OFS_RESET_CAUSE_FLAGS, 32'h04);
		$display("test warm resets done");
		@(posedge clk);
		ext_reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		ext_reset_n <= 1'b1;
		repeat (PULSE + 6) @(posedge clk);
		rd_chk("flags", `OFS_RESET_CAUSE_FLAGS, 32'h00);
		$display("test external reset done");
		print_verdict();
	end
endmodule

bind reset_cause_remap_control reset_cause_remap_control_checker #(
	.PULSE_CYCLES(PULSE_CYCLES)
) chk (
	.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .watchdog_timeout(watchdog_timeout),
	.sram_at_zero(sram_at_zero), .sys_reset(sys_reset),
	.current_output_converter_reset(current_output_converter_reset),
	.voltage_dac_reset(voltage_dac_reset), .gpio_reset(gpio_reset)
);
